/* rtl/exec_pkg.sv */
// Package for the arithmetic, bit and branch execution unit.
// Assumes an 8-bit data path, 7-bit file addresses and a 15-bit program counter.
package exec_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int BIT_W = 3;
    localparam int PC_W = 15;
    localparam int OFS_W = 9;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int NIB_HI = 4;
    localparam int DEST_W_REG = 0;
    localparam logic [DATA_W-1:0] W_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
    localparam logic [PC_W-1:0] PC_ONE = 15'h0001;
    // Cycles taken by a branch or a taken skip
    localparam int TWO_CYCLE = 2;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_ADD_W_TO_FILE,
        OP_ADD_W_FILE_WITH_CARRY,
        OP_ARITH_SHIFT_RIGHT_FILE,
        OP_BIT_CLEAR_FILE,
        OP_BIT_TEST_SKIP_IF_CLEAR,
        OP_RELATIVE_BRANCH
    } op_t;

    typedef struct packed {
        op_t op;
        logic [ADDR_W-1:0] addr;
        logic dest;
        logic [BIT_W-1:0] bit_sel;
        logic [OFS_W-1:0] offset;
    } instr_t;

    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic zero;
    } flags_t;

    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } file_wr_t;

    typedef struct packed {
        logic [DATA_W-1:0] result;
        flags_t flags;
        logic upd_c;
        logic upd_dz;
    } alu_out_t;
endpackage : exec_pkg

/* rtl/exec_alu.sv */
// Combinational result and flag logic for the execution unit.
// Assumes operands are stable in the cycle the core presents them.
`timescale 1ns/1ps
module exec_alu (
    // Operation and operands
    input wire exec_pkg::op_t op_in,
    input wire logic [exec_pkg::DATA_W-1:0] w_in,
    input wire logic [exec_pkg::DATA_W-1:0] f_in,
    input wire logic [exec_pkg::BIT_W-1:0] bit_sel_in,
    input wire exec_pkg::flags_t flags_in,
    // Result
    output exec_pkg::alu_out_t res_out
);
    import exec_pkg::*;

    logic [DATA_W:0] sum;
    logic [NIB_HI:0] nib;
    logic cin;

    always_comb begin
        cin = (op_in == OP_ADD_W_FILE_WITH_CARRY) ? flags_in.carry : 1'b0;
        sum = {1'b0, w_in} + {1'b0, f_in} + {{DATA_W{1'b0}}, cin};
        nib = {1'b0, w_in[NIB_HI-1:0]} + {1'b0, f_in[NIB_HI-1:0]} + {{NIB_HI{1'b0}}, cin};
        res_out = '0;
        res_out.flags = flags_in;
        case (op_in)
            OP_ADD_W_TO_FILE, OP_ADD_W_FILE_WITH_CARRY: begin
                res_out.result = sum[DATA_W-1:0];
                res_out.flags.carry = sum[DATA_W];
                res_out.flags.digit_carry_flag = nib[NIB_HI];
                res_out.upd_c = 1'b1;
                res_out.upd_dz = 1'b1;
            end
            OP_ARITH_SHIFT_RIGHT_FILE: begin
                res_out.result = {f_in[DATA_W-1], f_in[DATA_W-1:1]};
                res_out.flags.carry = f_in[0];
                res_out.upd_c = 1'b1;
                res_out.upd_dz = 1'b0;
            end
            OP_BIT_CLEAR_FILE: begin
                res_out.result = f_in & ~(8'h01 << bit_sel_in);
            end
            default: begin
                res_out.result = f_in;
            end
        endcase
        res_out.flags.zero = (res_out.upd_c) ? (res_out.result == 8'h00) : flags_in.zero;
    end
endmodule : exec_alu

/* rtl/arith_bit_branch_exec.sv */
// Execution unit for add, add with carry, arithmetic shift, bit clear,
// bit test with skip and relative branch.
// Assumes the decoder presents one instruction per cycle with instr_valid_in,
// and that file data for the addressed register arrives on file_rd_in.
//
// Summary of operation
// - Add W and file register, set flags
// - Destination bit picks W or file
// - Add with carry sums W, file, carry
// - Shift bits 7..1 down; bit0 to carry
// - Shift keeps sign bit; updates C, Z
// - Bit clear zeroes only selected bit
// - Tested bit set: no skip
// - Tested bit clear: next becomes no-op
// - Branch to PC+1 plus signed offset
// - Branch takes two cycles, flushes next
`timescale 1ns/1ps
module arith_bit_branch_exec (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic srst_in,
    // Decoded instruction
    input wire logic instr_valid_in,
    input wire exec_pkg::instr_t instr_in,
    // Data memory read data for instr_in.addr
    input wire logic [exec_pkg::DATA_W-1:0] file_rd_in,
    // Data memory write
    output exec_pkg::file_wr_t file_wr_out,
    // Architectural state
    output logic [exec_pkg::DATA_W-1:0] w_out,
    output exec_pkg::flags_t flags_out,
    output logic [exec_pkg::PC_W-1:0] pc_out,
    // Pipeline control
    output logic flush_out,
    output logic busy_out
);
    import exec_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] w;
        flags_t flags;
        logic [PC_W-1:0] pc;
        file_wr_t wr;
        logic flush;
        logic busy;
        logic skip;
    } state_t;

    state_t st;
    state_t next_st;
    alu_out_t alu;
    logic take;

    exec_alu exec_alu_inst (
        .op_in(instr_in.op),
        .w_in(st.w),
        .f_in(file_rd_in),
        .bit_sel_in(instr_in.bit_sel),
        .flags_in(st.flags),
        .res_out(alu)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // The cycle after a branch or taken skip is the no-op slot; the decoder
    // may still present the flushed instruction there, so it is ignored.
    // Only a skip advances pc in that slot; a branch has already loaded its
    // target, and stepping past it would lose the first target instruction.
    always_comb begin
        next_st = st;
        next_st.wr.we = 1'b0;
        next_st.flush = 1'b0;
        next_st.busy = 1'b0;
        next_st.skip = 1'b0;
        take = instr_valid_in && !st.flush;
        if (take) begin
            next_st.pc = st.pc + PC_ONE;
            case (instr_in.op)
                OP_ADD_W_TO_FILE, OP_ADD_W_FILE_WITH_CARRY, OP_ARITH_SHIFT_RIGHT_FILE: begin
                    next_st.flags = alu.flags;
                    if (instr_in.dest == 1'(DEST_W_REG)) begin
                        next_st.w = alu.result;
                    end else begin
                        next_st.wr = '{we: 1'b1, addr: instr_in.addr, data: alu.result};
                    end
                end
                OP_BIT_CLEAR_FILE: begin
                    next_st.wr = '{we: 1'b1, addr: instr_in.addr, data: alu.result};
                end
                OP_BIT_TEST_SKIP_IF_CLEAR: begin
                    // Read only: no write, flags kept
                    if (!file_rd_in[instr_in.bit_sel]) begin
                        next_st.flush = 1'b1;
                        next_st.skip = 1'b1;
                        next_st.busy = 1'b1;
                    end
                end
                OP_RELATIVE_BRANCH: begin
                    next_st.pc = st.pc + PC_ONE
                        + {{(PC_W-OFS_W){instr_in.offset[OFS_W-1]}}, instr_in.offset};
                    next_st.flush = 1'b1;
                    next_st.busy = 1'b1;
                end
                default: begin
                end
            endcase
        end else if (instr_valid_in && st.skip) begin
            next_st.pc = st.pc + PC_ONE; // Slot of the discarded instruction
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            st <= '{w: W_RESET, flags: '0, pc: PC_RESET, wr: '0, flush: 1'b0, busy: 1'b0,
                skip: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign file_wr_out = st.wr;
    assign w_out = st.w;
    assign flags_out = st.flags;
    assign pc_out = st.pc;
    assign flush_out = st.flush;
    assign busy_out = st.busy;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    add_dest_w_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        instr_valid_in && !flush_out && instr_in.op == OP_ADD_W_TO_FILE && !instr_in.dest
        |=> w_out == $past(w_out) + $past(file_rd_in) && !file_wr_out.we)
        else $error("add to W wrong");
    add_carry_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        instr_valid_in && !flush_out && instr_in.op == OP_ADD_W_FILE_WITH_CARRY
        |=> flags_out.carry == (({1'b0, $past(w_out)} + {1'b0, $past(file_rd_in)}
            + 9'($past(flags_out.carry))) > 9'h0FF))
        else $error("add with carry flag wrong");
    shift_result_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        instr_valid_in && !flush_out && instr_in.op == OP_ARITH_SHIFT_RIGHT_FILE
        && instr_in.dest |=> file_wr_out.we && file_wr_out.data[7] == $past(file_rd_in[7])
        && file_wr_out.data[6:0] == $past(file_rd_in[7:1])
        && flags_out.carry == $past(file_rd_in[0]))
        else $error("shift result wrong");
    shift_keep_dc_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        instr_valid_in && !flush_out && instr_in.op == OP_ARITH_SHIFT_RIGHT_FILE
        |=> $stable(flags_out.digit_carry_flag))
        else $error("shift touched digit carry");
    clear_bit_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        instr_valid_in && !flush_out && instr_in.op == OP_BIT_CLEAR_FILE
        |=> file_wr_out.we && !file_wr_out.data[$past(instr_in.bit_sel)]
        && (file_wr_out.data | (8'h01 << $past(instr_in.bit_sel)))
           == ($past(file_rd_in) | (8'h01 << $past(instr_in.bit_sel))))
        else $error("bit clear wrong");
    skip_set_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        instr_valid_in && !flush_out && instr_in.op == OP_BIT_TEST_SKIP_IF_CLEAR
        && file_rd_in[instr_in.bit_sel] |=> !flush_out && !file_wr_out.we)
        else $error("skip taken on set bit");
    skip_clear_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        instr_valid_in && !flush_out && instr_in.op == OP_BIT_TEST_SKIP_IF_CLEAR
        && !file_rd_in[instr_in.bit_sel] |=> flush_out ##1 !flush_out)
        else $error("skip not taken on clear bit");
    branch_target_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        instr_valid_in && !flush_out && instr_in.op == OP_RELATIVE_BRANCH
        |=> flush_out && busy_out && pc_out == $past(pc_out) + 15'h0001
            + {{6{$past(instr_in.offset[8])}}, $past(instr_in.offset)})
        else $error("branch target wrong");
    flags_kept_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        instr_valid_in && !flush_out && (instr_in.op == OP_BIT_CLEAR_FILE
        || instr_in.op == OP_RELATIVE_BRANCH || instr_in.op == OP_BIT_TEST_SKIP_IF_CLEAR)
        |=> $stable(flags_out))
        else $error("flags changed");
    digit_carry_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        instr_valid_in && !flush_out && instr_in.op == OP_ADD_W_TO_FILE
        |=> flags_out.digit_carry_flag == (($past(w_out[3:0]) + $past(file_rd_in[3:0]))
            > 4'hF || (5'($past(w_out[3:0])) + 5'($past(file_rd_in[3:0]))) > 5'h0F)
        && flags_out.zero == ($past(w_out) + $past(file_rd_in) == 8'h00))
        else $error("digit carry or zero wrong");
    slot_ignored_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        instr_valid_in && flush_out
        |=> $stable(w_out) && $stable(flags_out) && !file_wr_out.we)
        else $error("flushed instruction executed");
    branch_slot_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        instr_valid_in && !flush_out && instr_in.op == OP_RELATIVE_BRANCH
        ##1 instr_valid_in |=> $stable(pc_out))
        else $error("branch target lost in flush slot");
    skip_slot_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        instr_valid_in && !flush_out && instr_in.op == OP_BIT_TEST_SKIP_IF_CLEAR
        && !file_rd_in[instr_in.bit_sel] ##1 instr_valid_in
        |=> pc_out == $past(pc_out) + 15'h0001)
        else $error("skip slot did not advance pc");
    test_no_write_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        instr_valid_in && !flush_out && instr_in.op == OP_BIT_TEST_SKIP_IF_CLEAR
        |=> !file_wr_out.we && $stable(w_out))
        else $error("bit test modified state");
    dest_file_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        instr_valid_in && !flush_out && instr_in.dest && (instr_in.op == OP_ADD_W_TO_FILE
        || instr_in.op == OP_ADD_W_FILE_WITH_CARRY || instr_in.op == OP_ARITH_SHIFT_RIGHT_FILE)
        |=> file_wr_out.we && file_wr_out.addr == $past(instr_in.addr)
        && $stable(w_out))
        else $error("file destination wrong");
    addc_result_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        instr_valid_in && !flush_out && instr_in.op == OP_ADD_W_FILE_WITH_CARRY && !instr_in.dest
        |=> w_out == 8'($past(w_out) + $past(file_rd_in) + 8'($past(flags_out.carry)))
        && flags_out.digit_carry_flag == ((5'($past(w_out[3:0])) + 5'($past(file_rd_in[3:0]))
            + 5'($past(flags_out.carry))) > 5'h0F))
        else $error("add with carry result wrong");
endmodule : arith_bit_branch_exec

/* bench/arith_bit_branch_exec_tb.sv */
// Self-checking bench for the arithmetic, bit and branch execution unit.
// Assumes combinational file read data and one-cycle registered outputs.
`timescale 1ns/1ps
module arith_bit_branch_exec_tb;
    import exec_pkg::*;
    // ----------------------------------------------------------------
    // Clock, stimulus and bench model
    // ----------------------------------------------------------------
    logic sys_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic instr_valid_in = 1'b0;
    instr_t instr_in = '0;
    logic [7:0] file_rd_in = 8'h00;
    file_wr_t file_wr_out;
    logic [7:0] w_out;
    flags_t flags_out;
    logic [14:0] pc_out;
    logic flush_out;
    logic busy_out;
    logic [7:0] e_w;
    flags_t e_f;
    logic [14:0] e_pc;
    int bad_count = 0;
    int tests_run = 0;

    always #10 sys_clk_in = ~sys_clk_in;

    arith_bit_branch_exec arith_bit_branch_exec_inst (
        .sys_clk_in(sys_clk_in), .srst_in(srst_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .file_rd_in(file_rd_in), .file_wr_out(file_wr_out),
        .w_out(w_out), .flags_out(flags_out), .pc_out(pc_out),
        .flush_out(flush_out), .busy_out(busy_out)
    );
    // ----------------------------------------------------------------
    // Compare tasks
    // ----------------------------------------------------------------
    task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : cmp8
    task automatic cmp15(input string n, input logic [14:0] e, input logic [14:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : cmp15
    task automatic cmp1(input string n, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask : cmp1
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    // ----------------------------------------------------------------
    // Bus-free instruction driver with its own reference model
    // ----------------------------------------------------------------
    task automatic do_reset;
        @(posedge sys_clk_in);
        srst_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        e_w = 8'h00;
        e_f = '0;
        e_pc = 15'h0000;
        @(negedge sys_clk_in);
        cmp8("w", e_w, w_out);
        cmp8("flags", 8'h00, {5'h00, flags_out});
        cmp15("pc", e_pc, pc_out);
        cmp1("we", 1'b0, file_wr_out.we);
        cmp1("flush", 1'b0, flush_out);
    endtask : do_reset
    task automatic exec(input op_t op, input logic [6:0] a, input logic d, input logic [2:0] b,
                        input logic [8:0] o, input logic [7:0] f);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] r;
        logic cin;
        logic ewe;
        logic efl;
        @(posedge sys_clk_in);
        instr_in <= '{op, a, d, b, o};
        file_rd_in <= f;
        instr_valid_in <= 1'b1;
        @(posedge sys_clk_in);
        instr_valid_in <= 1'b0;
        r = e_w;
        ewe = 1'b0;
        efl = 1'b0;
        e_pc = e_pc + 15'h0001;
        cin = (op == OP_ADD_W_FILE_WITH_CARRY) & e_f.carry;
        case (op)
            OP_ADD_W_TO_FILE, OP_ADD_W_FILE_WITH_CARRY: begin
                s = {1'b0, e_w} + {1'b0, f} + {8'h00, cin};
                h = {1'b0, e_w[3:0]} + {1'b0, f[3:0]} + {4'h0, cin};
                r = s[7:0];
                e_f = '{s[8], h[4], r == 8'h00};
            end
            OP_ARITH_SHIFT_RIGHT_FILE: begin
                r = {f[7], f[7:1]};
                e_f.carry = f[0];
                e_f.zero = (r == 8'h00);
            end
            OP_BIT_CLEAR_FILE: begin
                r = f & ~(8'h01 << b);
                ewe = 1'b1;
            end
            OP_BIT_TEST_SKIP_IF_CLEAR: efl = ~f[b];
            OP_RELATIVE_BRANCH: begin
                e_pc = e_pc + {{6{o[8]}}, o};
                efl = 1'b1;
            end
            default: ;
        endcase
        if (op inside {OP_ADD_W_TO_FILE, OP_ADD_W_FILE_WITH_CARRY, OP_ARITH_SHIFT_RIGHT_FILE}) begin
            if (d) ewe = 1'b1;
            else e_w = r;
        end
        @(negedge sys_clk_in);
        cmp8("w", e_w, w_out);
        cmp8("flags", {5'h00, e_f}, {5'h00, flags_out});
        cmp15("pc", e_pc, pc_out);
        cmp1("we", ewe, file_wr_out.we);
        cmp1("flush", efl, flush_out);
        cmp1("busy", efl, busy_out);
        if (ewe) cmp8("data", r, file_wr_out.data);
        if (ewe) cmp8("addr", {1'b0, a}, {1'b0, file_wr_out.addr});
    endtask : exec
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic arith_cases;
        exec(OP_ADD_W_TO_FILE, 7'h10, 1'b0, 3'h0, 9'h000, 8'h3c);
        exec(OP_ADD_W_TO_FILE, 7'h7f, 1'b1, 3'h0, 9'h000, 8'h08);
        exec(OP_ADD_W_TO_FILE, 7'h00, 1'b0, 3'h0, 9'h000, 8'hc4);
        exec(OP_ADD_W_FILE_WITH_CARRY, 7'h21, 1'b1, 3'h0, 9'h000, 8'h0f);
        exec(OP_ADD_W_FILE_WITH_CARRY, 7'h22, 1'b0, 3'h0, 9'h000, 8'hff);
        exec(OP_ARITH_SHIFT_RIGHT_FILE, 7'h30, 1'b0, 3'h0, 9'h000, 8'h81);
        exec(OP_ARITH_SHIFT_RIGHT_FILE, 7'h31, 1'b1, 3'h0, 9'h000, 8'h01);
        exec(OP_ARITH_SHIFT_RIGHT_FILE, 7'h32, 1'b0, 3'h0, 9'h000, 8'h7e);
    endtask : arith_cases
    task automatic bit_cases;
        for (int i = 0; i < 8; i++) begin
            exec(OP_BIT_CLEAR_FILE, 7'h40 + 7'(i), 1'b0, 3'(i), 9'h000, 8'hff);
            exec(OP_BIT_TEST_SKIP_IF_CLEAR, 7'h50, 1'b0, 3'(i), 9'h000, 8'ha5);
        end
    endtask : bit_cases
    task automatic branch_cases;
        exec(OP_RELATIVE_BRANCH, 7'h00, 1'b0, 3'h0, 9'h0ff, 8'h00);
        exec(OP_RELATIVE_BRANCH, 7'h00, 1'b0, 3'h0, 9'h100, 8'h00);
        exec(OP_RELATIVE_BRANCH, 7'h00, 1'b0, 3'h0, 9'h1ff, 8'h00);
    endtask : branch_cases
    // Next instruction arrives in the no-op slot and must leave W untouched
    task automatic discard(input op_t op, input logic [8:0] o, input logic [14:0] inc);
        @(posedge sys_clk_in);
        instr_in <= '{op, 7'h05, 1'b0, 3'h3, o};
        file_rd_in <= 8'h00;
        instr_valid_in <= 1'b1;
        @(posedge sys_clk_in);
        instr_in <= '{OP_ADD_W_TO_FILE, 7'h06, 1'b0, 3'h0, 9'h000};
        file_rd_in <= 8'h55;
        @(posedge sys_clk_in);
        instr_valid_in <= 1'b0;
        e_pc = e_pc + inc;
        @(negedge sys_clk_in);
        cmp8("w", e_w, w_out);
        cmp15("pc", e_pc, pc_out);
        cmp1("flush", 1'b0, flush_out);
        cmp1("we", 1'b0, file_wr_out.we);
    endtask : discard
    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        do_reset();
        arith_cases();
        bit_cases();
        branch_cases();
        discard(OP_RELATIVE_BRANCH, 9'h004, 15'h0005);
        discard(OP_BIT_TEST_SKIP_IF_CLEAR, 9'h000, 15'h0002);
        do_reset();
        arith_cases();
        wrap_up();
    end
    // Whole run needs some 84 cycles; the margin covers a stalled design
    initial begin
        repeat (5000) @(posedge sys_clk_in);
        bad_count++;
        wrap_up();
    end
endmodule : arith_bit_branch_exec_tb
